// file: design/switch_defs.svh
`ifndef SWITCH_DEFS_SVH
`define SWITCH_DEFS_SVH

// port counts and path widths
`define SW_NUM_M        4
`define SW_NUM_S        3
`define SW_ADDR_W       32
`define SW_DATA_W       64
`define SW_PRIO_W       2

// address decode field: top nibble selects the region
`define SW_DEC_HI       31
`define SW_DEC_LO       28
`define SW_REG_FLASH    4'h0
`define SW_REG_SRAM     4'h4
`define SW_REG_BRIDGE   4'hc

// slave port numbers
`define SW_S_FLASH      2'h0
`define SW_S_SRAM       2'h1
`define SW_S_BRIDGE     2'h2

// reset values
`define SW_RR_LAST_RST  2'h0

`endif

// file: design/switch_pkg.sv
package switch_pkg;

    typedef enum logic [1:0]
    {
        SLOT_IDLE = 2'b00,
        SLOT_BUSY = 2'b01,
        SLOT_DONE = 2'b10
    } slot_state_t;

endpackage

// file: design/addr_region_decode.sv
`timescale 1ns/100ps
`include "switch_defs.svh"

module addr_region_decode
(
    // request address
    input  wire logic [`SW_ADDR_W-1:0] addr,
    // decoded slave port
    output logic      [1:0]            sel,
    output logic                       hit
);

    always_comb
    begin
        sel = `SW_S_BRIDGE;
        hit = 1'b1;
        case (addr[`SW_DEC_HI:`SW_DEC_LO])
            `SW_REG_FLASH:  sel = `SW_S_FLASH;
            `SW_REG_SRAM:   sel = `SW_S_SRAM;
            `SW_REG_BRIDGE: sel = `SW_S_BRIDGE;
            default:        hit = 1'b0;
        endcase
    end

endmodule

// file: design/slave_port_arbiter.sv
`timescale 1ns/100ps
`include "switch_defs.svh"

module slave_port_arbiter
#(
    parameter int NM = `SW_NUM_M,
    parameter int PW = `SW_PRIO_W + 1,
    parameter int IW = $clog2(NM)
)
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // contenders
    input  wire logic [NM-1:0]          req,
    input  wire logic [NM-1:0][PW-1:0]  prio,
    input  wire logic                   rr_mode,
    input  wire logic                   take,
    // winner
    output logic      [IW-1:0]          grant,
    output logic                        any
);

    // the scan needs an index of at least one bit
    if (NM < 2 || PW < 1)
        $error("slave_port_arbiter: needs two contenders and a priority");

    logic [IW-1:0] last_ff;
    logic [PW-1:0] best;
    logic [IW-1:0] idx;

    // rr scans from the slot after the last winner; the strict compare
    // keeps the first one found among equals
    always_comb
    begin
        grant = '0;
        any   = 1'b0;
        best  = '0;
        idx   = '0;
        for (int k = 1; k <= NM; k++)
        begin
            if (rr_mode)
                idx = IW'((int'(last_ff) + k) % NM);
            else
                idx = IW'(k - 1);
            if (req[idx] && (!any || prio[idx] > best))
            begin
                any   = 1'b1;
                best  = prio[idx];
                grant = idx;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            last_ff <= IW'(`SW_RR_LAST_RST);
        else if (take && any)
            last_ff <= grant;
    end

endmodule

// file: design/multi_port_switch.sv
`timescale 1ns/100ps
`include "switch_defs.svh"

module multi_port_switch
#(
    parameter int NM = `SW_NUM_M,
    parameter int NS = `SW_NUM_S,
    parameter int AW = `SW_ADDR_W,
    parameter int DW = `SW_DATA_W,
    parameter int PW = `SW_PRIO_W
)
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // arbitration control
    input  wire logic                  rr_mode,
    input  wire logic [NM-1:0][PW-1:0] prio_level,
    input  wire logic [NM-1:0]         prio_elevate,
    // master ports: 0 core fetch, 1 core data, 2 dma, 3 network
    input  wire logic [NM-1:0]         m_req,
    input  wire logic [NM-1:0]         m_lock,
    input  wire logic [NM-1:0]         m_we,
    input  wire logic [NM-1:0][AW-1:0] m_addr,
    input  wire logic [NM-1:0][DW-1:0] m_wdata,
    output logic      [NM-1:0]         m_ack,
    output logic      [NM-1:0]         m_err,
    output logic      [NM-1:0][DW-1:0] m_rdata,
    // slave ports: 0 flash, 1 sram, 2 peripheral bridge
    output logic      [NS-1:0]         s_req,
    output logic      [NS-1:0]         s_we,
    output logic      [NS-1:0][AW-1:0] s_addr,
    output logic      [NS-1:0][DW-1:0] s_wdata,
    input  wire logic [NS-1:0]         s_ack,
    input  wire logic [NS-1:0][DW-1:0] s_rdata
);

    localparam int IW = $clog2(NM);

    // the decoder and port numbering are fixed to this map
    if (NM != `SW_NUM_M || NS != `SW_NUM_S)
        $error("multi_port_switch: port counts must be 4 masters, 3 slaves");
    if (AW != `SW_ADDR_W || DW != `SW_DATA_W)
        $error("multi_port_switch: paths must be 32-bit address, 64-bit data");
    if (PW < 1)
        $error("multi_port_switch: priority level needs at least one bit");

    ////////////////////////////////////////////////////////////////////////
    // per-master decode and effective priority

    logic [NM-1:0][1:0]    m_sel;
    logic [NM-1:0]         m_hit;
    logic [NM-1:0]         m_live;
    logic [NM-1:0][PW:0]   eff_prio;

    for (genvar m = 0; m < NM; m++)
    begin : g_mdec
        addr_region_decode u_dec
        (
            .addr (m_addr[m]),
            .sel  (m_sel[m]),
            .hit  (m_hit[m])
        );

        // the ack cycle is the one in which the master drops or swaps
        // its request, so it never counts as a fresh one
        assign m_live[m] = m_req[m] && !m_ack[m];

        // elevation sits above every programmed level; in rr mode only
        // the elevation bit counts so the rest share one level
        always_comb
        begin
            eff_prio[m] = {prio_elevate[m], prio_level[m]};
            if (rr_mode)
                eff_prio[m] = {prio_elevate[m], {PW{1'b0}}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave ports, each with its own arbiter and owner

    logic [NS-1:0]          done_ev;
    logic [NS-1:0][IW-1:0]  owner;

    for (genvar s = 0; s < NS; s++)
    begin : g_slv
        switch_pkg::slot_state_t state_ff;
        logic [IW-1:0]  owner_ff;
        logic           locked_ff;
        logic           lock_req_ff;
        logic [NM-1:0]  want;
        logic [IW-1:0]  win;
        logic           win_any;
        logic           own_wants;
        logic           take;
        logic [IW-1:0]  pick;
        logic           start;

        always_comb
        begin
            for (int m = 0; m < NM; m++)
                want[m] = m_live[m] && m_hit[m] && (m_sel[m] == 2'(s));
        end

        assign own_wants = locked_ff && want[owner_ff];
        // a locked port ignores everyone but its owner
        assign take = (state_ff == switch_pkg::SLOT_IDLE) && !locked_ff
                      && win_any;

        // the lock owner goes first, otherwise the arbiter's winner
        assign pick  = own_wants ? owner_ff : win;
        assign start = (state_ff == switch_pkg::SLOT_IDLE)
                       && (own_wants || take);

        slave_port_arbiter #(.NM(NM), .PW(PW + 1)) u_arb
        (
            .core_clk (core_clk),
            .arst_n   (arst_n),
            .req      (want),
            .prio     (eff_prio),
            .rr_mode  (rr_mode),
            .take     (take),
            .grant    (win),
            .any      (win_any)
        );

        assign done_ev[s] = (state_ff == switch_pkg::SLOT_BUSY) && s_ack[s];
        assign owner[s]   = owner_ff;

        // slot sequencing
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                state_ff <= switch_pkg::SLOT_IDLE;
            else
            begin
                case (state_ff)
                    switch_pkg::SLOT_IDLE:
                    begin
                        if (start)
                            state_ff <= switch_pkg::SLOT_BUSY;
                    end
                    switch_pkg::SLOT_BUSY:
                    begin
                        if (s_ack[s])
                            state_ff <= switch_pkg::SLOT_DONE;
                    end
                    // one quiet cycle lets the master see its ack and
                    // drop the request before it could be reissued
                    switch_pkg::SLOT_DONE:
                        state_ff <= switch_pkg::SLOT_IDLE;
                    default:
                        state_ff <= switch_pkg::SLOT_IDLE;
                endcase
            end
        end

        // owner and its lock wish are captured as the slot starts
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                owner_ff    <= '0;
                lock_req_ff <= 1'b0;
            end
            else if (start)
            begin
                owner_ff    <= pick;
                lock_req_ff <= m_lock[pick];
            end
        end

        // strobe rises as the slot starts and falls on the answer
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                s_req[s] <= 1'b0;
            else if (start)
                s_req[s] <= 1'b1;
            else if (s_ack[s])
                s_req[s] <= 1'b0;
        end

        // fields stay put from the start until the answer
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                s_we[s]    <= 1'b0;
                s_addr[s]  <= '0;
                s_wdata[s] <= '0;
            end
            else if (start)
            begin
                s_we[s]    <= m_we[pick];
                s_addr[s]  <= m_addr[pick];
                s_wdata[s] <= m_wdata[pick];
            end
        end

        // ownership survives the answer while the winner keeps its lock
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                locked_ff <= 1'b0;
            else if (done_ev[s])
                locked_ff <= lock_req_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answers back to the masters

    for (genvar m = 0; m < NM; m++)
    begin : g_ret
        logic          nxt_ack;
        logic          nxt_err;
        logic [DW-1:0] nxt_rdata;

        // each master is owed at most one answer at a time, so slaves
        // never collide on a master's return path
        always_comb
        begin
            nxt_ack   = 1'b0;
            nxt_err   = 1'b0;
            nxt_rdata = m_rdata[m];
            if (m_live[m] && !m_hit[m])
            begin
                nxt_ack   = 1'b1;
                nxt_err   = 1'b1;
                nxt_rdata = '0;
            end
            for (int s = 0; s < NS; s++)
            begin
                if (done_ev[s] && owner[s] == IW'(m))
                begin
                    nxt_ack   = 1'b1;
                    nxt_rdata = s_rdata[s];
                end
            end
        end

        // read data is held between answers, so a slow master may
        // pick it up after the ack pulse has gone
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                m_ack[m]   <= 1'b0;
                m_err[m]   <= 1'b0;
                m_rdata[m] <= '0;
            end
            else
            begin
                m_ack[m]   <= nxt_ack;
                m_err[m]   <= nxt_err;
                m_rdata[m] <= nxt_rdata;
            end
        end
    end

    // port order above is the master and slave allocation
    // a channel copy is simply another instance; nothing is shared

endmodule

// file: sim/slave_model.sv
`timescale 1ns/100ps
module slave_model
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // answer delay in cycles
    input  wire logic [2:0]       dly,
    // slave ports
    input  wire logic [2:0]       s_req,
    input  wire logic [2:0]       s_we,
    input  wire logic [2:0][31:0] s_addr,
    input  wire logic [2:0][63:0] s_wdata,
    output logic      [2:0]       s_ack,
    output logic      [2:0][63:0] s_rdata
);
    logic [2:0][2:0]  cnt_ff;
    logic [2:0][63:0] mem_ff;

    // one word per slave; reads fold in the address so a stale word shows
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_ack <= '0;
            s_rdata <= '0;
            cnt_ff <= '0;
            mem_ff <= '0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                s_ack[k] <= 1'b0;
                if (s_req[k] && !s_ack[k] && cnt_ff[k] == dly)
                begin
                    s_ack[k] <= 1'b1;
                    cnt_ff[k] <= '0;
                    s_rdata[k] <= mem_ff[k] ^ {2{s_addr[k]}};
                    if (s_we[k])
                        mem_ff[k] <= s_wdata[k];
                end
                else if (s_req[k] && !s_ack[k])
                    cnt_ff[k] <= cnt_ff[k] + 3'h1;
                else
                begin
                    // released bus never repeats the last word
                    cnt_ff[k] <= '0;
                    s_rdata[k] <= ~s_rdata[k];
                end
            end
        end
    end
endmodule

// file: sim/multi_port_switch_chk.sv
`timescale 1ns/100ps
`include "switch_defs.svh"
module multi_port_switch_chk
#(
    parameter int NM = 4,
    parameter int NS = 3,
    parameter int AW = 32,
    parameter int DW = 64
)
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // master side
    input  wire logic [NM-1:0]         m_req,
    input  wire logic [NM-1:0][AW-1:0] m_addr,
    input  wire logic [NM-1:0]         m_ack,
    input  wire logic [NM-1:0]         m_err,
    input  wire logic [NM-1:0][DW-1:0] m_rdata,
    // slave side
    input  wire logic [NS-1:0]         s_req,
    input  wire logic [NS-1:0][AW-1:0] s_addr,
    input  wire logic [NS-1:0]         s_ack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    localparam logic [2:0][3:0] region_tab =
        {`SW_REG_BRIDGE, `SW_REG_SRAM, `SW_REG_FLASH};
    ////////////////////////////////////////////////////////////////////
    for (genvar k = 0; k < NS; k++)
    begin : g_s
        sequence s_wait; s_req[k] && !s_ack[k]; endsequence
        sequence s_done; s_req[k] && s_ack[k]; endsequence
        a_sreq_held: assert property (
            s_wait |=> s_req[k] && $stable(s_addr[k]))
            else $error("slave request left early");
        a_sreq_drop: assert property (
            s_done |=> !s_req[k] ##1 !s_req[k])
            else $error("slave request not dropped");
        a_sreq_region: assert property (
            $rose(s_req[k]) |-> s_addr[k][31:28] == region_tab[k])
            else $error("slave got foreign address");
        a_ack_back: assert property (
            s_done |=> (m_ack & ~m_err) != '0)
            else $error("slave answer not passed back");
    end
    ////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < NM; i++)
    begin : g_m
        sequence s_bad;
            $rose(m_req[i]) && !(m_addr[i][31:28] inside
                {`SW_REG_FLASH, `SW_REG_SRAM, `SW_REG_BRIDGE});
        endsequence
        a_ack_pulse: assert property (
            m_ack[i] |=> !m_ack[i])
            else $error("master ack longer than a cycle");
        a_err_ack: assert property (m_err[i] |-> m_ack[i])
            else $error("error without ack");
        a_err_fast: assert property (s_bad |=> m_ack[i] && m_err[i])
            else $error("unmapped access not refused");
        a_rdata_hold: assert property (
            !m_ack[i] |-> $stable(m_rdata[i]))
            else $error("read data moved without ack");
    end
endmodule

bind multi_port_switch multi_port_switch_chk
#(.NM(NM), .NS(NS), .AW(AW), .DW(DW)) chk_i
(
    .core_clk(core_clk), .arst_n(arst_n), .m_req(m_req),
    .m_addr(m_addr), .m_ack(m_ack), .m_err(m_err),
    .m_rdata(m_rdata), .s_req(s_req), .s_addr(s_addr), .s_ack(s_ack)
);

// file: sim/tb_multi_port_switch.sv
`timescale 1ns/100ps
module tb_multi_port_switch;
    logic             core_clk;
    logic             arst_n;
    logic             rr_mode;
    logic [3:0][1:0]  prio_level;
    logic [3:0]       prio_elevate, m_req, m_lock, m_we, m_ack, m_err, er;
    logic [3:0][31:0] m_addr;
    logic [3:0][63:0] m_wdata, m_rdata, rd;
    logic [2:0]       s_req, s_we, s_ack, dly;
    logic [2:0][31:0] s_addr;
    logic [2:0][63:0] s_wdata, s_rdata;
    int               err_count, n_tests, lat[4], ord[$];

    always #12.5 core_clk = ~core_clk;

    multi_port_switch multi_port_switch_i
    (
        .core_clk(core_clk), .arst_n(arst_n), .rr_mode(rr_mode),
        .prio_level(prio_level), .prio_elevate(prio_elevate),
        .m_req(m_req), .m_lock(m_lock), .m_we(m_we), .m_addr(m_addr),
        .m_wdata(m_wdata), .m_ack(m_ack), .m_err(m_err),
        .m_rdata(m_rdata), .s_req(s_req), .s_we(s_we), .s_addr(s_addr),
        .s_wdata(s_wdata), .s_ack(s_ack), .s_rdata(s_rdata)
    );
    slave_model slave_model_i
    (
        .core_clk(core_clk), .arst_n(arst_n), .dly(dly), .s_req(s_req),
        .s_we(s_we), .s_addr(s_addr), .s_wdata(s_wdata), .s_ack(s_ack),
        .s_rdata(s_rdata)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string w, input logic [63:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset;
        arst_n = 1'b0;
        m_req = '0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
    endtask
    task automatic put(input int i, input logic [31:0] a, input logic w,
                       input logic [63:0] d, input logic lk);
        m_addr[i] = a;
        m_we[i] = w;
        m_wdata[i] = d;
        m_lock[i] = lk;
        m_req[i] = 1'b1;
    endtask
    // masters drop their request inside the ack cycle
    task automatic run;
        int n;
        n = 0;
        er = '0;
        ord.delete();
        while (m_req !== 4'h0 && n < 200)
        begin
            @(negedge core_clk);
            n++;
            for (int i = 0; i < 4; i++)
                if (m_ack[i] === 1'b1)
                begin
                    ord.push_back(i);
                    lat[i] = n;
                    rd[i] = m_rdata[i];
                    er[i] = m_err[i];
                    m_req[i] = 1'b0;
                end
        end
        check("all answered", m_req, '0);
        @(negedge core_clk);
    endtask
    task automatic put_all(input logic [3:0] mk);
        for (int i = 0; i < 4; i++)
            if (mk[i])
                put(i, 32'h4000_0000 + 32'(i * 8), 1'b0, '0, 1'b0);
        run();
    endtask
    task automatic order_is(input string w, input logic [15:0] e);
        logic [15:0] g;
        g = '0;
        foreach (ord[j])
            g = {g[11:0], 4'(ord[j])};
        check(w, g, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_basic;
        put(1, 32'h4000_0010, 1'b1, 64'h1122_3344_5566_7788, 1'b0);
        run();
        check("latency", lat[1], 3);
        put(1, 32'h4000_0010, 1'b0, '0, 1'b0);
        run();
        check("read back", rd[1], 64'h5122_3354_1566_7798);
        $display("t_basic done");
    endtask
    task automatic t_lock;
        prio_level = 8'h0c;
        put(2, 32'h4000_0040, 1'b0, '0, 1'b1);
        run();
        put(1, 32'h4000_0048, 1'b0, '0, 1'b0);
        put(2, 32'h4000_0050, 1'b0, '0, 1'b0);
        run();
        order_is("lock order", 16'h0021);
        $display("t_lock done");
    endtask
    task automatic t_prio;
        logic [7:0]  lv[3] = '{8'he4, 8'h1b, 8'h00};
        logic [15:0] ex[3] = '{16'h3210, 16'h0123, 16'h0123};
        for (int j = 0; j < 3; j++)
        begin
            prio_level = lv[j];
            put_all(4'hf);
            order_is("fixed order", ex[j]);
        end
        $display("t_prio done");
    endtask
    task automatic t_elev;
        // master 0 outranks master 3 until its lift ends
        prio_level = 8'hc0;
        prio_elevate = 4'h1;
        put_all(4'h9);
        order_is("elevated", 16'h0003);
        prio_elevate = 4'h0;
        put_all(4'h9);
        order_is("elevation ended", 16'h0030);
        $display("t_elev done");
    endtask
    task automatic t_rr;
        do_reset();
        rr_mode = 1'b1;
        put_all(4'hf);
        order_is("rr after reset", 16'h1230);
        put_all(4'hd);
        order_is("rr from last", 16'h0230);
        prio_elevate = 4'h8;
        put_all(4'hf);
        order_is("rr elevated", 16'h3012);
        prio_elevate = 4'h0;
        $display("t_rr done");
    endtask
    task automatic t_conc;
        dly = 3'h2;
        put(0, 32'h0000_0100, 1'b0, '0, 1'b0);
        put(1, 32'h4000_0020, 1'b0, '0, 1'b0);
        put(2, 32'hc000_0030, 1'b0, '0, 1'b0);
        put(3, 32'h8000_0000, 1'b0, '0, 1'b0);
        run();
        for (int i = 0; i < 3; i++)
            check("parallel latency", lat[i], 5);
        check("flash fetch", rd[0], {2{32'h0000_0100}});
        check("error flags", er, 4'h8);
        check("error latency", lat[3], 1);
        check("error data", rd[3], '0);
        $display("t_conc done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        rr_mode = 1'b0;
        prio_level = '0;
        prio_elevate = '0;
        m_lock = '0;
        m_we = '0;
        m_addr = '0;
        m_wdata = '0;
        dly = '0;
        err_count = 0;
        n_tests = 0;
        do_reset();
        t_basic();
        t_lock();
        t_prio();
        t_elev();
        t_rr();
        t_conc();
        final_report();
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        final_report();
    end
endmodule
